// >>> vac_defs.svh
// Constants for the attribute controller: ports, indices, fields, timing.
// Assumes 16-bit legacy I/O addresses and byte-wide data.
`ifndef VAC_DEFS_SVH
`define VAC_DEFS_SVH

// Host I/O ports
`define VAC_PORT_INDEX 16'h03C0
`define VAC_PORT_DATA_RD 16'h03C1
`define VAC_PORT_STAT_MONO 16'h03BA
`define VAC_PORT_STAT_COLOR 16'h03DA

// Register indices
`define VAC_IDX_PAL_LAST 5'h0F
`define VAC_IDX_MODE 5'h10
`define VAC_IDX_BORDER 5'h11
`define VAC_IDX_PLANE 5'h12
`define VAC_IDX_PAN 5'h13
`define VAC_IDX_CSEL 5'h14

// Index register fields
`define VAC_INDEX_VIDEO_EN 5

// Mode control fields
`define VAC_MODE_P54_SEL 7
`define VAC_MODE_PIX8 6
`define VAC_MODE_PAN_TOP 5
`define VAC_MODE_BLINK 3
`define VAC_MODE_LINE_GFX 2
`define VAC_MODE_MONO 1
`define VAC_MODE_GRAPHICS 0
`define VAC_MODE_WR_MASK 8'hEF

// Line graphics character range
`define VAC_LINE_GFX_LO 8'hB0
`define VAC_LINE_GFX_HI 8'hDF

// Status mux encodings
`define VAC_SMUX_P20 2'h0
`define VAC_SMUX_P54 2'h1
`define VAC_SMUX_P31 2'h2
`define VAC_SMUX_P76 2'h3

// Reset values
`define VAC_RESET_BYTE 8'h00

// Blink timing: vertical syncs per blink half-period
`define VAC_BLINK_FRAMES 5'h10

`endif

// >>> vac_pkg.sv
// Types shared by the attribute controller modules.
// Assumes vac_defs.svh supplies the numeric constants.
package vac_pkg;

  // Index/data flip-flop of the shared write port
  typedef enum logic {
    VAC_FF_INDEX = 1'b0,
    VAC_FF_DATA = 1'b1
  } vac_ff_t;

  // Nibble pairing phase for the 8-bit pixel mode
  typedef enum logic {
    VAC_PAIR_HI = 1'b0,
    VAC_PAIR_LO = 1'b1
  } vac_pair_t;

  typedef struct packed {
    vac_ff_t ff;
    logic [5:0] index;
    logic [15:0][5:0] pal;
    logic [7:0] mode;
    logic [7:0] border;
    logic [5:0] plane;
    logic [3:0] pan;
    logic [3:0] csel;
    logic [7:0] rdata;
    logic [7:0] pix_out;
    logic [1:0] status_bits;
    logic [3:0] pan_out;
  } vac_main_t;

  typedef struct packed {
    vac_pair_t phase;
    logic [3:0] hi;
    logic [7:0] byte_out;
  } vac_pair_st_t;

  typedef struct packed {
    logic vsync_d;
    logic [4:0] count;
    logic phase;
  } vac_blink_st_t;

endpackage

// >>> vac_blink_div.sv
// Blink phase generator: divides vertical sync into a slow square wave.
// Assumes vsync is synchronous to clk and high for at least one cycle.
`timescale 1ns/1ps
`include "vac_defs.svh"

module vac_blink_div
  import vac_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic vsync,
  output logic blink_phase
);

  vac_blink_st_t s;
  vac_blink_st_t next_s;

  // Count rising edges of vsync; toggle the phase each half-period
  always_comb
  begin
    next_s = s;
    next_s.vsync_d = vsync;
    if (vsync && !s.vsync_d)
    begin
      if (s.count == `VAC_BLINK_FRAMES - 5'h01)
      begin
        next_s.count = 5'h00;
        next_s.phase = !s.phase;
      end
      else
      begin
        next_s.count = s.count + 5'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign blink_phase = s.phase;

endmodule

// >>> vac_pixel_pair.sv
// Pairs two 4-bit pixel values into one 8-bit index for 256-colour modes.
// Assumes one nibble per valid dot; the first nibble of a pair is the high one.
`timescale 1ns/1ps
`include "vac_defs.svh"

module vac_pixel_pair
  import vac_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [3:0] nibble,
  output logic [7:0] pair_byte
);

  vac_pair_st_t s;
  vac_pair_st_t next_s;

  // The byte updates every other dot and holds in between
  always_comb
  begin
    next_s = s;
    if (!enable)
    begin
      next_s.phase = VAC_PAIR_HI; // Realign at the start of each active run
    end
    else
    begin
      unique case (s.phase)
        VAC_PAIR_HI:
        begin
          next_s.hi = nibble;
          next_s.phase = VAC_PAIR_LO;
        end
        VAC_PAIR_LO:
        begin
          next_s.byte_out = {s.hi, nibble};
          next_s.phase = VAC_PAIR_HI;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign pair_byte = s.byte_out;

endmodule

// >>> vga_attribute_controller.sv
// Attribute controller: host register bank behind the legacy I/O ports,
// and the per-dot attribute-to-palette-index translation.
// Assumes clk is the dot clock, host strobes last one cycle, and the
// sequencer supplies glyph, attribute and plane data aligned per dot.
// The input status register lives elsewhere; only its read address is
// decoded here, to return the flip-flop to its index state.
// Back-to-back host accesses are allowed on every cycle.
//
// Behaviour
// - Shared write port alternates index then data
// - Input status read forces index-write state
// - Data port read leaves flip-flop unchanged
// - Index bits 4:0 select target register
// - Index bit 5 clear blanks pixels, opens palette
// - Palette gives P5..P0; colour select P7:P6
// - Mode bit 7 takes P5:P4 from colour select
// - Mode bit 6 pairs nibbles, bypassing palette
// - Mode bit 5 limits panning to upper region
// - Mode bit 3 picks blink or background intensity
// - Ninth dot copies eighth for line graphics
// - Mode bit 1 selects monochrome attribute decoding
// - Mode bit 0 selects text or graphics
// - Border shows overscan colour index
// - Status mux routes P2/P0, P5/P4, P3/P1, P7/P6
`timescale 1ns/1ps
`include "vac_defs.svh"

module vga_attribute_controller
  import vac_pkg::*;
(
  // Dot clock and synchronous reset
  input wire logic clk,
  input wire logic rst,
  // Host I/O strobes, one cycle per access
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Emulation choice; moves the status port between mono and colour
  input wire logic msr_color_emul,
  // Per-dot video timing and cell data from the sequencer
  input wire logic dot_active,
  input wire logic dot_border,
  input wire logic lower_region,
  input wire logic vsync,
  input wire logic glyph_bit,
  input wire logic ninth_col,
  input wire logic [7:0] char_code,
  input wire logic [7:0] attr_byte,
  input wire logic [3:0] plane_pix,
  // Per-dot results, all registered
  output logic [7:0] pixel_index,
  output logic [1:0] status_mux_bits,
  output logic [3:0] pan_shift,
  output logic graphics_mode,
  output logic attr_data_phase
);

  // Whole register bank and pixel stage in one state word
  vac_main_t s;
  vac_main_t next_s;
  // Square wave from the vsync divider; high while blinking items are off
  logic blink_phase;
  // Assembled byte of the 256-colour mode, already registered
  logic [7:0] pair_byte;
  logic [3:0] gfx_nibble;
  logic pair_enable;

  // Graphics nibble after plane masking, shared with the pairing stage
  assign gfx_nibble = plane_pix & s.plane[3:0];
  assign pair_enable = dot_active && s.mode[`VAC_MODE_PIX8];

  // Slow blink phase; only the pixel path reads it
  vac_blink_div u_blink
  (
    .clk(clk),
    .rst(rst),
    .vsync(vsync),
    .blink_phase(blink_phase)
  );

  // Pairing runs only on active dots of the 256-colour mode, so that
  // every active run starts again on a high nibble
  vac_pixel_pair u_pair
  (
    .clk(clk),
    .rst(rst),
    .enable(pair_enable),
    .nibble(gfx_nibble),
    .pair_byte(pair_byte)
  );

  // Read view of the indexed register; unmapped indices read as zero
  function automatic logic [7:0] reg_read(input vac_main_t st);
    logic [4:0] idx;
    logic [7:0] val;
    idx = st.index[4:0];
    val = 8'h00;
    if (idx <= `VAC_IDX_PAL_LAST)
    begin
      // Palette hidden from the host while video is enabled
      if (!st.index[`VAC_INDEX_VIDEO_EN])
        val = {2'b00, st.pal[idx[3:0]]};
    end
    // Reserved bits are never stored, so they read back as zero
    else if (idx == `VAC_IDX_MODE)
      val = st.mode;
    else if (idx == `VAC_IDX_BORDER)
      val = st.border;
    else if (idx == `VAC_IDX_PLANE)
      val = {2'b00, st.plane};
    else if (idx == `VAC_IDX_PAN)
      val = {4'h0, st.pan};
    else if (idx == `VAC_IDX_CSEL)
      val = {4'h0, st.csel};
    // Indices 15h to 1Fh fall through and read as zero
    return val;
  endfunction

  // Two selected palette bits for the status register
  function automatic logic [1:0] status_pick(input logic [1:0] sel, input logic [7:0] p);
    logic [1:0] r;
    // Encoding 11 completes the four-way choice with the top two bits
    r = 2'b00;
    unique case (sel)
      `VAC_SMUX_P20: r = {p[2], p[0]};
      `VAC_SMUX_P54: r = {p[5], p[4]};
      `VAC_SMUX_P31: r = {p[3], p[1]};
      `VAC_SMUX_P76: r = {p[7], p[6]};
    endcase
    return r;
  endfunction

  // Host port and pixel path in one next-state block
  always_comb
  begin
    logic [3:0] nib;
    logic [3:0] fg;
    logic [3:0] bg;
    logic [5:0] entry;
    logic [7:0] ci;
    logic on;
    logic line_gfx;
    logic blink_en;
    logic [15:0] stat_port;
    nib = 4'h0;
    fg = 4'h0;
    bg = 4'h0;
    entry = 6'h00;
    ci = 8'h00;
    on = 1'b0;
    line_gfx = 1'b0;
    blink_en = s.mode[`VAC_MODE_BLINK];
    // Status port address as chosen by the emulation input
    stat_port = msr_color_emul ? `VAC_PORT_STAT_COLOR : `VAC_PORT_STAT_MONO;
    next_s = s;

    // Writes to other addresses are ignored. A data write to a reserved
    // index still uses up the data phase, which keeps host software in
    // step with the flip-flop whatever it writes.
    // Shared port: index on one write, data on the next
    if (io_wr && io_addr == `VAC_PORT_INDEX)
    begin
      unique case (s.ff)
        VAC_FF_INDEX:
        begin
          // Bit 5 rides along with the index and gates the palette
          next_s.index = io_wdata[5:0];
          next_s.ff = VAC_FF_DATA;
        end
        VAC_FF_DATA:
        begin
          next_s.ff = VAC_FF_INDEX;
          // Palette writes are dropped while video owns the palette
          if (s.index[4:0] <= `VAC_IDX_PAL_LAST)
          begin
            if (!s.index[`VAC_INDEX_VIDEO_EN])
              next_s.pal[s.index[3:0]] = io_wdata[5:0];
          end
          // Reserved mode bit 4 is masked so that it always reads zero
          else if (s.index[4:0] == `VAC_IDX_MODE)
            next_s.mode = io_wdata & `VAC_MODE_WR_MASK;
          else if (s.index[4:0] == `VAC_IDX_BORDER)
            next_s.border = io_wdata;
          // Narrow registers keep only their defined bits
          else if (s.index[4:0] == `VAC_IDX_PLANE)
            next_s.plane = io_wdata[5:0];
          else if (s.index[4:0] == `VAC_IDX_PAN)
            next_s.pan = io_wdata[3:0];
          else if (s.index[4:0] == `VAC_IDX_CSEL)
            next_s.csel = io_wdata[3:0];
          // Indices 15h to 1Fh fall through and store nothing
        end
      endcase
    end

    // Reads: data port leaves the flip-flop alone; status read resets it
    if (io_rd)
    begin
      // The shared port also reads back the index, reserved bits as zero
      if (io_addr == `VAC_PORT_INDEX)
        next_s.rdata = {2'b00, s.index};
      else if (io_addr == `VAC_PORT_DATA_RD)
        next_s.rdata = reg_read(s);
      // Any other address reads as zero
      else
        next_s.rdata = `VAC_RESET_BYTE;
      // Applied last so a status read wins over a same-cycle write
      if (io_addr == stat_port)
        next_s.ff = VAC_FF_INDEX;
    end

    // Text attribute decode
    // The ninth column repeats the eighth dot only for line-drawing codes;
    // other cells show background there, so glyphs keep a gap between them
    line_gfx = s.mode[`VAC_MODE_LINE_GFX] &&
      char_code >= `VAC_LINE_GFX_LO && char_code <= `VAC_LINE_GFX_HI;
    on = ninth_col ? (line_gfx && glyph_bit) : glyph_bit;
    if (s.mode[`VAC_MODE_MONO])
    begin
      // Monochrome: on/off foreground, background lit only when its field is 7, whatever the foreground
      fg = {attr_byte[3], (attr_byte[2:0] != 3'h0) ? 3'h7 : 3'h0};
      bg = {blink_en ? 1'b0 : attr_byte[7],
        (attr_byte[6:4] == 3'h7) ? 3'h7 : 3'h0};
    end
    else
    begin
      // Colour: attribute nibbles map straight to palette entries
      fg = attr_byte[3:0];
      bg = {blink_en ? 1'b0 : attr_byte[7], attr_byte[6:4]};
    end
    // Blinking text only hides the foreground; background keeps showing
    if (blink_en && attr_byte[7] && blink_phase)
      on = 1'b0;

    // Text or graphics source nibble
    // Plane enables mask both paths, so a disabled plane reads as zero
    if (s.mode[`VAC_MODE_GRAPHICS])
    begin
      nib = gfx_nibble;
      // Graphics blink drops the intensity bit during the off phase
      if (blink_en && blink_phase)
        nib[3] = 1'b0;
    end
    else
    begin
      nib = (on ? fg : bg) & s.plane[3:0];
    end

    // Palette translation and colour select bits
    // Later overrides win: colour select, then pairing, then video off
    entry = s.pal[nib];
    ci = {s.csel[3:2], entry};
    if (s.mode[`VAC_MODE_P54_SEL])
      ci[5:4] = s.csel[1:0];
    if (s.mode[`VAC_MODE_PIX8])
      ci = pair_byte;
    // Video off forces index zero while timing and border carry on
    if (!s.index[`VAC_INDEX_VIDEO_EN])
      ci = 8'h00;

    // Active pixel overrides border, and border overrides blanking
    // Active dots win over border dots; outside both the index is zero
    if (dot_active)
      next_s.pix_out = ci;
    else if (dot_border)
      next_s.pix_out = s.border;
    else
      next_s.pix_out = 8'h00;


    // Status bits follow the active-path index, before the border override
    next_s.status_bits = status_pick(s.plane[5:4], ci);
    // Lower split region is left unshifted when the top-only bit is set
    next_s.pan_out = (s.mode[`VAC_MODE_PAN_TOP] && lower_region) ? 4'h0 : s.pan;
  end

  // Reset clears everything, leaving the flip-flop in index state
  // A zero palette shows black until the host loads it
  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  // Outputs straight from the state register
  // No logic sits between these flops and the pins
  assign io_rdata = s.rdata;
  assign pixel_index = s.pix_out;
  assign status_mux_bits = s.status_bits;
  assign pan_shift = s.pan_out;
  assign graphics_mode = s.mode[`VAC_MODE_GRAPHICS];
  assign attr_data_phase = s.ff;

endmodule

// >>> vac_chk_sva.sv
// Checker for the attribute controller host port and pixel output.
// Assumes it is bound into vga_attribute_controller; sync active-high reset.
`timescale 1ns/1ps
`include "vac_defs.svh"
module vac_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic msr_color_emul,
  input wire logic dot_active,
  input wire logic dot_border,
  input wire logic [7:0] pixel_index,
  input wire logic graphics_mode,
  input wire logic attr_data_phase
);
  logic stat_rd;
  logic idx_wr;
  logic data_wr;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Status port follows the emulation choice, so the wrong one must not clear
  assign stat_rd = io_rd &&
    io_addr == (msr_color_emul ? `VAC_PORT_STAT_COLOR : `VAC_PORT_STAT_MONO);
  assign idx_wr = io_wr && io_addr == `VAC_PORT_INDEX;
  // Data phase write: the one that may move a register
  assign data_wr = idx_wr && attr_data_phase;
  ff_toggle_a: assert property (
    idx_wr && !stat_rd |=> attr_data_phase != $past(attr_data_phase))
    else $error("phase did not toggle");
  stat_clear_a: assert property (
    stat_rd |=> !attr_data_phase)
    else $error("status read kept data phase");
  data_rd_keep_a: assert property (
    io_rd && !io_wr && !stat_rd |=> $stable(attr_data_phase))
    else $error("read moved phase");
  rdata_hold_a: assert property (
    !io_rd |=> $stable(io_rdata))
    else $error("read data moved");
  // The shared port reads back the index, so only other addresses read zero
  other_rd_zero_a: assert property (
    io_rd && io_addr != `VAC_PORT_DATA_RD && io_addr != `VAC_PORT_INDEX |=> io_rdata == 8'h00)
    else $error("stray read data");
  mode_src_a: assert property (
    $changed(graphics_mode) |-> $past(data_wr))
    else $error("mode moved without write");
  blank_zero_a: assert property (
    !dot_active && !dot_border |=> pixel_index == 8'h00)
    else $error("blank not zero");
  reset_state_a: assert property (
    $fell(rst) |-> !attr_data_phase && pixel_index == 8'h00 && io_rdata == 8'h00)
    else $error("bad reset state");
endmodule
bind vga_attribute_controller vac_chk chk (.clk(clk), .rst(rst), .io_addr(io_addr),
  .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .msr_color_emul(msr_color_emul),
  .dot_active(dot_active), .dot_border(dot_border), .pixel_index(pixel_index),
  .graphics_mode(graphics_mode), .attr_data_phase(attr_data_phase));

// >>> vac_host.sv
// Host CPU model issuing one-cycle legacy I/O strobes.
// Assumes the bench calls its tasks; released lines show inverted values.
`timescale 1ns/1ps
module vac_host (
  input wire logic clk,
  input wire logic [7:0] io_rdata,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  initial
  begin
    io_addr = 16'hFFFF;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'hFF;
  end
  // One write strobe; the status read before a sequence is up to the caller
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask
  // Read data is taken the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    #1 d = io_rdata;
  endtask
endmodule

// >>> tb.sv
// Self-checking bench for the attribute controller.
// Assumes vac_host drives the I/O strobes; pixel inputs driven here.
`timescale 1ns/1ps
`include "vac_defs.svh"
module tb;
  logic clk, rst, msr_color_emul, dot_active, dot_border, lower_region, vsync;
  logic glyph_bit, ninth_col;
  logic [7:0] char_code, attr_byte, io_rdata, io_wdata, pixel_index, d, bd, cs, md;
  logic [3:0] plane_pix, pan_shift;
  logic [15:0] io_addr;
  logic io_wr, io_rd, graphics_mode, attr_data_phase;
  logic [1:0] status_mux_bits;
  logic [22:0] r;
  logic [5:0] pal [16];
  int error_cnt = 0, n_checks = 0, cyc = 0;
  vac_host host (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));
  vga_attribute_controller dut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .msr_color_emul(msr_color_emul), .dot_active(dot_active), .dot_border(dot_border),
    .lower_region(lower_region), .vsync(vsync), .glyph_bit(glyph_bit),
    .ninth_col(ninth_col), .char_code(char_code), .attr_byte(attr_byte),
    .plane_pix(plane_pix), .pixel_index(pixel_index), .status_mux_bits(status_mux_bits),
    .pan_shift(pan_shift), .graphics_mode(graphics_mode),
    .attr_data_phase(attr_data_phase));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic setreg(input logic [7:0] i, input logic [7:0] v);
    host.wr(`VAC_PORT_INDEX, i);
    host.wr(`VAC_PORT_INDEX, v);
  endtask
  task automatic getreg(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] junk;
    host.wr(`VAC_PORT_INDEX, i);
    host.rd(`VAC_PORT_DATA_RD, d);
    cmp(d, e);
    cmp({7'h0, attr_data_phase}, 8'h01);
    // The data read leaves the data phase; a status read returns to index
    host.rd(msr_color_emul ? `VAC_PORT_STAT_COLOR : `VAC_PORT_STAT_MONO, junk);
  endtask
  // Palette colour with P7:P6 from colour select, P5:P4 per mode bit 7
  function automatic logic [7:0] col(input logic [3:0] n);
    return {cs[3:2], md[7] ? cs[1:0] : pal[n][5:4], pal[n][3:0]};
  endfunction
  function automatic logic [1:0] smux(input logic [7:0] p, input logic [1:0] s);
    case (s)
      2'h0: return {p[2], p[0]};
      2'h1: return {p[5], p[4]};
      2'h2: return {p[3], p[1]};
      default: return {p[7], p[6]};
    endcase
  endfunction
  task automatic dot(input logic [7:0] e, input logic [1:0] s);
    @(posedge clk);
    #1 cmp(pixel_index, e);
    if (dot_active)
      cmp({6'h0, status_mux_bits}, {6'h0, smux(e, s)});
  endtask
  initial
  begin
    rst = 1'b1;
    {msr_color_emul, dot_active, dot_border, lower_region, vsync, glyph_bit} = 6'h00;
    ninth_col = 1'b0;
    {char_code, attr_byte, plane_pix} = 20'h00000;
    void'($urandom(32'h8764));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 cmp({7'h0, attr_data_phase}, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      pal[i] = d[5:0];
      setreg(i[7:0], d);
      getreg(i[7:0], {2'h0, pal[i]});
    end
    bd = 8'($urandom);
    setreg(8'h11, bd);
    getreg(8'h11, bd);
    setreg(8'h10, 8'hFF);
    getreg(8'h10, `VAC_MODE_WR_MASK);
    getreg(8'h15, 8'h00);
    setreg(8'h23, 8'hAA);
    host.rd(`VAC_PORT_INDEX, d);
    cmp(d, 8'h23);
    getreg(8'h23, 8'h00);
    getreg(8'h03, {2'h0, pal[3]});
    for (int m = 0; m < 2; m++)
    begin
      msr_color_emul <= m[0];
      host.wr(`VAC_PORT_INDEX, 8'h00);
      host.rd(m ? `VAC_PORT_STAT_MONO : `VAC_PORT_STAT_COLOR, d);
      cmp({7'h0, attr_data_phase}, 8'h01);
      host.rd(m ? `VAC_PORT_STAT_COLOR : `VAC_PORT_STAT_MONO, d);
      cmp({7'h0, attr_data_phase}, 8'h00);
    end
    cs = 8'($urandom);
    setreg(8'h14, cs);
    for (int k = 0; k < 12; k++)
    begin
      md = k < 4 ? 8'h01 : (k < 8 ? 8'h81 : 8'h00);
      setreg(8'h32, {2'h0, k[1:0], 4'hF});
      setreg(8'h30, md);
      dot_active <= 1'b1;
      for (int j = 0; j < 20; j++)
      begin
        // Expectation from the drawn word, since the pins update only after the edge
        r = 23'($urandom);
        {plane_pix, attr_byte, glyph_bit, char_code, lower_region, vsync} <= r;
        dot(col(md[0] ? r[22:19] : (r[10] ? r[14:11] : r[18:15])), k[1:0]);
      end
      cmp({7'h0, graphics_mode}, {7'h0, md[0]});
    end
    // Monochrome text, line graphics on the ninth column, top-only panning
    md = 8'h26;
    setreg(8'h33, 8'h05);
    setreg(8'h30, md);
    {attr_byte, glyph_bit, ninth_col, char_code, lower_region} <=
      {8'h70, 1'b1, 1'b1, 8'hC4, 1'b1};
    dot(col(4'h0), 2'h3);
    cmp({4'h0, pan_shift}, 8'h00);
    {char_code, lower_region} <= {8'h41, 1'b0};
    dot(col(4'h7), 2'h3);
    cmp({4'h0, pan_shift}, 8'h05);
    // 256-colour pairing: first nibble is the high one, byte shows two dots on
    dot_active <= 1'b0;
    setreg(8'h30, 8'h41);
    r = 23'($urandom);
    dot_active <= 1'b1;
    plane_pix <= r[7:4];
    @(posedge clk);
    plane_pix <= r[3:0];
    @(posedge clk);
    dot(r[7:0], 2'h3);
    dot_active <= 1'b0;
    dot_border <= 1'b1;
    dot(bd, 2'h0);
    dot_active <= 1'b1;
    host.wr(`VAC_PORT_INDEX, 8'h00);
    dot(8'h00, 2'h0);
    give_verdict();
  end
endmodule
